// ### pdm_power_down_ctrl.sv
// power-down mode controller with ahb-lite register slave
// Functional notes
// - select field bits 15..10, read/write, reset zero
// - mode takes effect nine cycles after write
// - 001001 gates cpu, wakes on enabled interrupt
// - 010001 gates cpu, wakes on any interrupt
// - gating stops cpu clock, interrupt logic runs
// - dma keeps running while cpu is gated
// - non-enabled wake resumes without service routine
// - enabled wake runs service routine, then resumes
// - service routine needs global and nmi enable
// - 011010 stops pll output, whole chip halts
// - 011100 stops pll input, relock after reset
// - pll-stop modes left only by reset
// - pll-stop modes keep registers and ram
// - pll-stop modes freeze functional outputs
// - reference clock input gated only in 011100
// - lock wait 75 us plus 150 percent
// - cpu clock from pll or bypass
`timescale 1ns/1ps
`default_nettype none
module pdm_power_down_ctrl #(
   parameter int unsigned LOCK_WAIT_CYCLES = pdm_pkg::LOCK_WAIT_CYC,
   parameter int unsigned LOCK_W = 16
) (
   // clock and device reset
   input wire logic clk,
   input wire logic rst,
   // ahb-lite slave
   input wire pdm_pkg::pdm_ahb_addr_t ahbAddr,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata_ff,
   output logic hreadyout_ff,
   output logic hresp_ff,
   // interrupt state from the cpu core
   input wire pdm_pkg::pdm_irq_t irqIn,
   // pll multiply strap pin, high selects pll, low bypass
   input wire logic pllMultiplySelect,
   // clock gating controls
   output logic cpuClockEnable_ff,
   output logic intLogicClockEnable_ff,
   output logic dmaClockEnable_ff,
   output logic pllOutputEnable_ff,
   output logic refClockEnable_ff,
   output logic pllBypass_ff,
   // chip-wide effects
   output logic ioFreeze_ff,
   output logic stateRetain_ff,
   // wake handshake to the cpu core
   output logic isrRequest_ff,
   output logic resumeNoIsr_ff
);
   // ==========================================================
   // state and registers
   pdm_pkg::pdm_state_t state_ff;
   pdm_pkg::pdm_state_t nxt_state;
   logic [5:0] field_ff;
   logic [5:0] nxt_field;
   logic gie_ff;
   logic nxt_gie;
   logic wrPend_ff;
   logic [7:0] wrAddr_ff;
   logic [3:0] entryCnt_ff;
   logic [3:0] nxt_entryCnt;
   logic [LOCK_W-1:0] lockCnt_ff;
   logic [LOCK_W-1:0] nxt_lockCnt;
   logic strap1_ff;
   logic strap2_ff;
   logic nxt_bypass;

   // ==========================================================
   // bus decode
   wire addrPhase = ahbAddr.hsel && ahbAddr.htrans[1] && ahbAddr.hready;
   wire rdReq = addrPhase && !ahbAddr.hwrite;
   wire wrReq = addrPhase && ahbAddr.hwrite;
   wire wrCsr = wrPend_ff && (wrAddr_ff == pdm_pkg::CSR_OFFSET);
   wire [5:0] wrField = hwdata[pdm_pkg::POWER_DOWN_SELECT_FIELD_MSB:pdm_pkg::POWER_DOWN_SELECT_FIELD_LSB];
   wire rdCsr = ahbAddr.haddr[7:0] == pdm_pkg::CSR_OFFSET;
   wire rdStatus = ahbAddr.haddr[7:0] == pdm_pkg::STATUS_OFFSET;
   wire hiZero = ahbAddr.haddr[31:8] == 24'h00_0000;

   // ==========================================================
   // mode decode
   // unknown values keep running
   wire fieldGateEn = field_ff == pdm_pkg::POWER_DOWN_SELECT_FIELD_GATE_ENABLED;
   wire fieldGateAny = field_ff == pdm_pkg::POWER_DOWN_SELECT_FIELD_GATE_ANY;
   wire fieldPllOut = field_ff == pdm_pkg::POWER_DOWN_SELECT_FIELD_PLL_OUT_STOP;
   wire fieldPllIn = field_ff == pdm_pkg::POWER_DOWN_SELECT_FIELD_PLL_IN_STOP;
   wire fieldGate = fieldGateEn || fieldGateAny;
   wire fieldLegal = fieldGate || fieldPllOut || fieldPllIn;
   wire entryDone = entryCnt_ff == 4'(pdm_pkg::ENTRY_DELAY_CYC - 1);

   // ==========================================================
   // wake logic
   wire wakeEnabled = |(irqIn.pending & irqIn.enabled);
   wire wakeAny = |irqIn.pending;
   wire wakeByEnabled = fieldGateEn && wakeEnabled;
   wire wakeByAny = fieldGateAny && wakeAny;
   wire gatedWake = (state_ff == pdm_pkg::ST_GATED) && (wakeByEnabled || wakeByAny);
   // service routine only with both enables
   wire runIsr = gatedWake && wakeEnabled && gie_ff && irqIn.nmiEnable;

   // ==========================================================
   // pll lock wait after reset
   // lock wait length
   wire lockDone = lockCnt_ff == LOCK_W'(LOCK_WAIT_CYCLES - 1);
   wire strapSettled = lockCnt_ff >= LOCK_W'(pdm_pkg::STRAP_SETTLE_CYC);
   wire lockExit = strapSettled && (strap2_ff ? lockDone : 1'b1);

   // ==========================================================
   // next-state logic
   always_comb begin
      nxt_state = state_ff;
      nxt_entryCnt = entryCnt_ff;
      nxt_lockCnt = lockCnt_ff;
      unique case (state_ff)
         pdm_pkg::ST_LOCK: begin
            nxt_lockCnt = lockCnt_ff + LOCK_W'(1);
            if (lockExit) begin
               nxt_state = pdm_pkg::ST_RUN;
            end
         end
         pdm_pkg::ST_RUN: begin
            nxt_entryCnt = 4'h0;
            if (fieldLegal) begin
               nxt_state = pdm_pkg::ST_ENTRY;
            end
         end
         pdm_pkg::ST_ENTRY: begin
            nxt_entryCnt = entryCnt_ff + 4'h1;
            if (!fieldLegal) begin
               nxt_state = pdm_pkg::ST_RUN;
            end else if (entryDone) begin
               nxt_state = fieldGate ? pdm_pkg::ST_GATED : pdm_pkg::ST_HALT;
            end
         end
         pdm_pkg::ST_GATED: begin
            if (gatedWake) begin
               nxt_state = pdm_pkg::ST_RUN;
            end
         end
         pdm_pkg::ST_HALT: begin
            nxt_state = pdm_pkg::ST_HALT;
         end
         default: begin
            nxt_state = pdm_pkg::ST_RUN;
         end
      endcase
   end

   // field write, cleared on cpu wake, write wins
   assign nxt_field = wrCsr ? wrField : (gatedWake ? pdm_pkg::POWER_DOWN_SELECT_FIELD_NONE : field_ff);
   assign nxt_gie = wrCsr ? hwdata[pdm_pkg::GIE_BIT] : gie_ff;
   assign nxt_bypass = (state_ff == pdm_pkg::ST_LOCK) ? !strap2_ff : pllBypass_ff;

   // csr read uses next values so back-to-back write then read sees new data
   wire [31:0] csrRead = {16'h0000, nxt_field, 9'h000, nxt_gie};
   wire [31:0] statusRead = {23'h00_0000, pllBypass_ff, 3'h0, state_ff};
   wire [31:0] rdMux = !hiZero ? pdm_pkg::RDATA_NONE :
                       rdCsr ? csrRead :
                       rdStatus ? statusRead : pdm_pkg::RDATA_NONE;

   // ==========================================================
   // gating decode from next state, so outputs line up with state_ff
   wire nxtHalt = nxt_state == pdm_pkg::ST_HALT;
   wire nxtGated = nxt_state == pdm_pkg::ST_GATED;
   wire nxtLock = nxt_state == pdm_pkg::ST_LOCK;
   // cpu clock blocked at cpu boundary
   wire nxtCpuClk = !(nxtGated || nxtHalt || nxtLock);
   wire nxtDmaClk = !(nxtHalt || nxtLock);
   // pll output stopped in both pll-stop modes
   wire nxtPllOut = !nxtHalt;
   // reference clock gated only in input-stop mode
   wire nxtRefClk = !(nxtHalt && (nxt_field == pdm_pkg::POWER_DOWN_SELECT_FIELD_PLL_IN_STOP));

   // ==========================================================
   // bus registers
   always_ff @(posedge clk) begin
      if (rst) begin
         wrPend_ff <= 1'b0;
         wrAddr_ff <= 8'h00;
         hrdata_ff <= pdm_pkg::RDATA_NONE;
         hreadyout_ff <= 1'b0;
         hresp_ff <= pdm_pkg::HRESP_OKAY;
      end else begin
         wrPend_ff <= wrReq && hiZero;
         wrAddr_ff <= ahbAddr.haddr[7:0];
         hrdata_ff <= rdReq ? rdMux : hrdata_ff;
         hreadyout_ff <= 1'b1;
         hresp_ff <= pdm_pkg::HRESP_OKAY;
      end
   end

   // ==========================================================
   // strap synchroniser
   always_ff @(posedge clk) begin
      if (rst) begin
         strap1_ff <= 1'b0;
         strap2_ff <= 1'b0;
      end else begin
         strap1_ff <= pllMultiplySelect;
         strap2_ff <= strap1_ff;
      end
   end

   // ==========================================================
   // control registers
   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff <= pdm_pkg::ST_LOCK;
         field_ff <= pdm_pkg::POWER_DOWN_SELECT_FIELD_RESET;
         gie_ff <= pdm_pkg::GIE_RESET;
         entryCnt_ff <= 4'h0;
         lockCnt_ff <= '0;
         pllBypass_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         field_ff <= nxt_field;
         gie_ff <= nxt_gie;
         entryCnt_ff <= nxt_entryCnt;
         lockCnt_ff <= nxt_lockCnt;
         pllBypass_ff <= nxt_bypass;
      end
   end

   // ==========================================================
   // clock and effect outputs
   always_ff @(posedge clk) begin
      if (rst) begin
         cpuClockEnable_ff <= 1'b0;
         intLogicClockEnable_ff <= 1'b0;
         dmaClockEnable_ff <= 1'b0;
         pllOutputEnable_ff <= 1'b1;
         refClockEnable_ff <= 1'b1;
         ioFreeze_ff <= 1'b0;
         stateRetain_ff <= 1'b0;
         isrRequest_ff <= 1'b0;
         resumeNoIsr_ff <= 1'b0;
      end else begin
         cpuClockEnable_ff <= nxtCpuClk;
         intLogicClockEnable_ff <= !(nxtHalt || nxtLock);
         dmaClockEnable_ff <= nxtDmaClk;
         pllOutputEnable_ff <= nxtPllOut;
         refClockEnable_ff <= nxtRefClk;
         stateRetain_ff <= nxtHalt;
         ioFreeze_ff <= nxtHalt;
         isrRequest_ff <= runIsr;
         resumeNoIsr_ff <= gatedWake && !runIsr;
      end
   end

   // ==========================================================
   // checks
   // reset clears field
   a_field_reset: assert property (@(posedge clk) rst |=> (field_ff == pdm_pkg::POWER_DOWN_SELECT_FIELD_RESET))
      else $error("select field not cleared by reset");

   a_field_write: assert property (@(posedge clk) disable iff (rst)
      wrCsr |=> (field_ff == $past(wrField)))
      else $error("select field did not take written value");

   a_entry_delay: assert property (@(posedge clk) disable iff (rst)
      ($rose(state_ff == pdm_pkg::ST_ENTRY) && fieldLegal && !wrCsr)
      |-> (state_ff == pdm_pkg::ST_ENTRY)[*8] ##1 (state_ff == pdm_pkg::ST_ENTRY)
      ##1 (state_ff != pdm_pkg::ST_ENTRY))
      else $error("power-down entry delay not nine cycles");

   a_wake_enabled_only: assert property (@(posedge clk) disable iff (rst)
      (state_ff == pdm_pkg::ST_GATED && fieldGateEn && !wakeEnabled)
      |=> (state_ff == pdm_pkg::ST_GATED))
      else $error("gated mode left without enabled interrupt");

   a_wake_any_irq: assert property (@(posedge clk) disable iff (rst)
      (state_ff == pdm_pkg::ST_GATED && fieldGateAny && wakeAny)
      |=> (state_ff == pdm_pkg::ST_RUN) && (resumeNoIsr_ff || isrRequest_ff))
      else $error("any-interrupt wake did not resume");

   a_gated_clocks: assert property (@(posedge clk) disable iff (rst)
      (state_ff == pdm_pkg::ST_GATED)
      |-> (!cpuClockEnable_ff && dmaClockEnable_ff && intLogicClockEnable_ff))
      else $error("wrong clock enables in gated mode");

   a_isr_enables: assert property (@(posedge clk) disable iff (rst)
      isrRequest_ff |-> $past(gie_ff && irqIn.nmiEnable && wakeEnabled) && !resumeNoIsr_ff)
      else $error("service routine requested without both enables");

   a_resume_cause: assert property (@(posedge clk) disable iff (rst)
      resumeNoIsr_ff |-> ($past(state_ff) == pdm_pkg::ST_GATED) && (state_ff == pdm_pkg::ST_RUN))
      else $error("plain resume outside a gated wake");

   a_halt_sticky: assert property (@(posedge clk) disable iff (rst)
      (state_ff == pdm_pkg::ST_HALT)
      |=> (state_ff == pdm_pkg::ST_HALT) && ($stable(field_ff) || $past(wrCsr)))
      else $error("pll-stop mode left without reset");

   a_halt_effects: assert property (@(posedge clk) disable iff (rst)
      (state_ff == pdm_pkg::ST_HALT)
      |-> (ioFreeze_ff && stateRetain_ff && !pllOutputEnable_ff && !cpuClockEnable_ff))
      else $error("halt effects missing in pll-stop mode");

   a_ref_gate: assert property (@(posedge clk) disable iff (rst)
      !refClockEnable_ff |-> (state_ff == pdm_pkg::ST_HALT) && (field_ff == pdm_pkg::POWER_DOWN_SELECT_FIELD_PLL_IN_STOP))
      else $error("reference clock gated outside input-stop mode");

   a_reserved_runs: assert property (@(posedge clk) disable iff (rst)
      (state_ff == pdm_pkg::ST_RUN && !fieldLegal) |=> (state_ff == pdm_pkg::ST_RUN))
      else $error("reserved select value left normal running");

   a_lock_wait: assert property (@(posedge clk) disable iff (rst)
      (state_ff == pdm_pkg::ST_LOCK && strap2_ff && !lockDone) |=> (state_ff == pdm_pkg::ST_LOCK))
      else $error("lock wait cut short");

   a_bus_okay: assert property (@(posedge clk) disable iff (rst)
      hresp_ff == pdm_pkg::HRESP_OKAY)
      else $error("slave answered other than okay");

endmodule : pdm_power_down_ctrl
`default_nettype wire

// ### pdm_pkg.sv
// package: constants, register map and types of the power-down mode controller
package pdm_pkg;
   // ==========================================================
   // clock and timing
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned ENTRY_DELAY_CYC = 9;
   localparam int unsigned LOCK_TYP_US = 75;
   localparam int unsigned LOCK_MARGIN_PCT = 150;
   localparam int unsigned LOCK_WAIT_NS = LOCK_TYP_US * 1000 * (100 + LOCK_MARGIN_PCT) / 100;
   localparam int unsigned LOCK_WAIT_CYC = (LOCK_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned STRAP_SETTLE_CYC = 3;
   localparam int unsigned IRQ_NUM = 8;
   // ==========================================================
   // register map
   localparam logic [7:0] CSR_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam int unsigned POWER_DOWN_SELECT_FIELD_LSB = 10;
   localparam int unsigned POWER_DOWN_SELECT_FIELD_MSB = 15;
   localparam int unsigned GIE_BIT = 0;
   localparam int unsigned STATUS_BYPASS_BIT = 8;
   localparam logic [5:0] POWER_DOWN_SELECT_FIELD_RESET = 6'h00;
   localparam logic [5:0] POWER_DOWN_SELECT_FIELD_NONE = 6'h00;
   localparam logic [5:0] POWER_DOWN_SELECT_FIELD_GATE_ENABLED = 6'h09;
   localparam logic [5:0] POWER_DOWN_SELECT_FIELD_GATE_ANY = 6'h11;
   localparam logic [5:0] POWER_DOWN_SELECT_FIELD_PLL_OUT_STOP = 6'h1a;
   localparam logic [5:0] POWER_DOWN_SELECT_FIELD_PLL_IN_STOP = 6'h1c;
   localparam logic GIE_RESET = 1'b0;
   localparam logic [31:0] RDATA_NONE = 32'h0000_0000;
   localparam logic HRESP_OKAY = 1'b0;
   // ==========================================================
   // types
   typedef enum logic [4:0] {
      ST_RUN = 5'h01,
      ST_ENTRY = 5'h02,
      ST_GATED = 5'h04,
      ST_HALT = 5'h08,
      ST_LOCK = 5'h10
   } pdm_state_t;
   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic hready;
   } pdm_ahb_addr_t;
   typedef struct packed {
      logic [IRQ_NUM-1:0] pending;
      logic [IRQ_NUM-1:0] enabled;
      logic nmiEnable;
   } pdm_irq_t;
endpackage : pdm_pkg

// ### pdm_cpu_core_model.sv
// cpu core model: raises interrupts and takes the wake pulses
`timescale 1ns/1ps
`default_nettype none
module pdm_cpu_core_model (
   // clock and device reset
   input wire logic clk,
   input wire logic rst,
   // bench commands: 1 plain interrupt, 2 enabled interrupt
   input wire logic [1:0] irqCmd,
   input wire logic nmiOn,
   // wake handshake and interrupt state
   input wire logic isrRequest,
   input wire logic resumeNoIsr,
   output pdm_pkg::pdm_irq_t irqOut,
   output logic [7:0] isrCount,
   output logic [7:0] resumeCount
);
   // ==========================================================
   // interrupt lines and wake counters
   always_ff @(posedge clk) begin
      if (rst) begin
         irqOut <= '0;
         isrCount <= 8'h00;
         resumeCount <= 8'h00;
      end else begin
         irqOut.nmiEnable <= nmiOn;
         if (irqCmd != 2'h0) begin
            irqOut.pending <= 8'h01;
            irqOut.enabled <= {7'h00, irqCmd[1]};
         end else if (isrRequest || resumeNoIsr) begin
            // wake taken, interrupt acknowledged
            irqOut.pending <= 8'h00;
         end
         if (isrRequest) isrCount <= isrCount + 8'h01;
         if (resumeNoIsr) resumeCount <= resumeCount + 8'h01;
      end
   end
endmodule : pdm_cpu_core_model
`default_nettype wire

// ### testbench.sv
// testbench of the power-down mode controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int LOCK = 20;
   logic clk, rst, strap, hsel, hwrite, nmiOn;
   logic [31:0] haddr, hwdata, hrdata, v;
   logic [1:0] htrans, irqCmd;
   logic hready, hresp, cpuEn, intEn, dmaEn, pllOutEn, refEn, bypass, freeze, retain, isrReq, resumeReq;
   logic [7:0] isrCount, resumeCount;
   logic [5:0] rsv [4] = '{6'h01, 6'h08, 6'h1e, 6'h00};
   pdm_pkg::pdm_ahb_addr_t busAddr;
   pdm_pkg::pdm_irq_t irq;
   int miscompares, samplesChecked;
   assign busAddr = {hsel, haddr, htrans, hwrite, 3'h2, hready};
   // ==========================================================
   // design and core model
   pdm_power_down_ctrl #(.LOCK_WAIT_CYCLES(LOCK)) u_pdm_power_down_ctrl (.clk(clk), .rst(rst),
      .ahbAddr(busAddr), .hwdata(hwdata), .hrdata_ff(hrdata), .hreadyout_ff(hready), .hresp_ff(hresp),
      .irqIn(irq), .pllMultiplySelect(strap), .cpuClockEnable_ff(cpuEn), .intLogicClockEnable_ff(intEn),
      .dmaClockEnable_ff(dmaEn), .pllOutputEnable_ff(pllOutEn), .refClockEnable_ff(refEn),
      .pllBypass_ff(bypass), .ioFreeze_ff(freeze), .stateRetain_ff(retain), .isrRequest_ff(isrReq),
      .resumeNoIsr_ff(resumeReq));
   pdm_cpu_core_model u_pdm_cpu_core_model (.clk(clk), .rst(rst), .irqCmd(irqCmd), .nmiOn(nmiOn),
      .isrRequest(isrReq), .resumeNoIsr(resumeReq), .irqOut(irq), .isrCount(isrCount),
      .resumeCount(resumeCount));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // ==========================================================
   // tasks
   task tallyAndFinish;
      $display("checks %0d mismatches %0d", samplesChecked, miscompares);
      if (miscompares == 0 && samplesChecked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : tallyAndFinish
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task waitReady;
      int n;
      n = 0;
      @(posedge clk);
      while (hready !== 1'b1) begin
         n++;
         if (n > 100) begin
            miscompares++;
            tallyAndFinish;
         end
         @(posedge clk);
      end
   endtask : waitReady
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      waitReady;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwrite <= 1'b0;
      hwdata <= wd;
      waitReady;
      rd = hrdata;
   endtask : bus
   task expectReg(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk(r & mask, exp);
   endtask : expectReg
   task waitCpu(input logic lvl, output int n);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (cpuEn !== lvl && n < 200);
      if (n >= 200) begin
         miscompares++;
         tallyAndFinish;
      end
   endtask : waitCpu
   task doReset(input logic s);
      int n;
      @(posedge clk);
      strap <= s;
      rst <= 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      waitCpu(1'b1, n);
      chk(n >= (s ? LOCK : 1) && n <= (s ? LOCK + 6 : 10), 1'b1);
      expectReg(pdm_pkg::STATUS_OFFSET, 32'h11f, {23'h0, ~s, 8'h01});
      expectReg(pdm_pkg::CSR_OFFSET, 32'hffff_ffff, 32'h0);
      chk({pllOutEn, refEn, freeze, intEn, dmaEn}, 5'h1b);
      $display("reset and lock test done");
   endtask : doReset
   task gateCase(input logic [5:0] f, input logic g, input logic [1:0] c, input logic nm, input logic isr);
      logic [7:0] i0, r0;
      int n;
      nmiOn <= nm;
      bus(1'b1, pdm_pkg::CSR_OFFSET, {16'h0, f, 9'h0, g}, v);
      waitCpu(1'b0, n);
      chk(n <= 11, 1'b1);
      chk({intEn, dmaEn}, 2'h3);
      expectReg(pdm_pkg::STATUS_OFFSET, 32'h1f, 32'h04);
      if (f == pdm_pkg::POWER_DOWN_SELECT_FIELD_GATE_ENABLED) begin
         @(posedge clk);
         irqCmd <= 2'h1;
         @(posedge clk);
         irqCmd <= 2'h0;
         repeat (6) @(negedge clk);
         chk(cpuEn, 1'b0);
      end
      i0 = isrCount;
      r0 = resumeCount;
      @(posedge clk);
      irqCmd <= c;
      @(posedge clk);
      irqCmd <= 2'h0;
      waitCpu(1'b1, n);
      repeat (2) @(negedge clk);
      chk({isrCount - i0, resumeCount - r0}, isr ? 16'h0100 : 16'h0001);
      expectReg(pdm_pkg::CSR_OFFSET, 32'hffff, {31'h0, g});
      $display("gating test %h done", f);
   endtask : gateCase
   task haltCase(input logic [5:0] f, input logic s);
      strap <= s;
      bus(1'b1, pdm_pkg::CSR_OFFSET, {16'h0, f, 10'h0}, v);
      repeat (12) @(negedge clk);
      chk({cpuEn, pllOutEn, refEn, freeze, retain}, {2'h0, f != pdm_pkg::POWER_DOWN_SELECT_FIELD_PLL_IN_STOP, 2'h3});
      @(posedge clk);
      irqCmd <= 2'h2;
      nmiOn <= 1'b1;
      @(posedge clk);
      irqCmd <= 2'h0;
      repeat (8) @(negedge clk);
      chk({cpuEn, pllOutEn, isrReq, resumeReq}, 4'h0);
      expectReg(pdm_pkg::CSR_OFFSET, 32'hfc00, {16'h0, f, 10'h0});
      doReset(s);
      $display("halt test %h done", f);
   endtask : haltCase
   // ==========================================================
   // main sequence
   initial begin
      rst = 1'b1;
      strap = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      irqCmd = 2'h0;
      nmiOn = 1'b0;
      miscompares = 0;
      samplesChecked = 0;
      doReset(1'b1);
      chk(hresp, 1'b0);
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, pdm_pkg::CSR_OFFSET, {16'h0, rsv[i], 10'h0}, v);
         repeat (14) @(negedge clk);
         chk(cpuEn, 1'b1);
         expectReg(pdm_pkg::STATUS_OFFSET, 32'h1f, 32'h01);
         expectReg(pdm_pkg::CSR_OFFSET, 32'hfc00, {16'h0, rsv[i], 10'h0});
      end
      bus(1'b1, 8'h08, 32'hffff_ffff, v);
      expectReg(8'h08, 32'hffff_ffff, 32'h0);
      expectReg(pdm_pkg::CSR_OFFSET, 32'hffff_ffff, 32'h0);
      $display("register test done");
      gateCase(pdm_pkg::POWER_DOWN_SELECT_FIELD_GATE_ENABLED, 1'b1, 2'h2, 1'b1, 1'b1);
      gateCase(pdm_pkg::POWER_DOWN_SELECT_FIELD_GATE_ANY, 1'b1, 2'h1, 1'b1, 1'b0);
      gateCase(pdm_pkg::POWER_DOWN_SELECT_FIELD_GATE_ENABLED, 1'b0, 2'h2, 1'b1, 1'b0);
      gateCase(pdm_pkg::POWER_DOWN_SELECT_FIELD_GATE_ENABLED, 1'b1, 2'h2, 1'b0, 1'b0);
      haltCase(pdm_pkg::POWER_DOWN_SELECT_FIELD_PLL_OUT_STOP, 1'b1);
      haltCase(pdm_pkg::POWER_DOWN_SELECT_FIELD_PLL_IN_STOP, 1'b0);
      tallyAndFinish;
   end
endmodule : testbench
`default_nettype wire
